// ---- core/fieldbus_master_state_control.sv ----
// fieldbus master: communications state machine, cyclic and acyclic scheduling
// Contract
// RQ1: link is full duplex at 100 Mbps
// RQ2: cyclic process data exchanged every control cycle
// RQ3: acyclic transfers only between cyclic exchanges
// RQ4: init state allows no traffic at all
// RQ5: state machine starts in init state
// RQ6: init done goes pre-op, acyclic only
// RQ7: safe-op: acyclic allowed, cyclic inputs only
// RQ8: operational only after current inputs obtained
// RQ9: operational: acyclic and cyclic both active
// RQ10: state changes happen without host action
// RQ11: state shown in status field and indicators
// RQ12: local time base follows shared network time
// RQ13: remote i/o refreshes on each host refresh
// RQ14: table maps host memory onto cyclic objects
// RQ15: unsupported slave refuses configuration, no communications
// RQ16: advance in order; errors drop to output-blocking state
`default_nettype none
module fieldbus_master_state_control #(
	parameter int CYCLE_NS = fieldbus_pkg::CYCLE_NS_DEF // control cycle in ns
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	// link pins and link engine
	input  wire logic                                 link_up_i,     // phy link pin, asynchronous
	output logic                                      link_fdx_o,    // full duplex request
	output logic                                      link_100_o,    // 100 Mbps request
	input  wire logic                                 scan_done_i,   // slave scan finished
	input  wire logic                                 unsupported_i, // scan found unsupported slave
	input  wire logic                                 setup_done_i,  // network parameters written
	input  wire logic                                 link_err_i,    // frame or slave error pulse
	input  wire logic                                 time_load_i,   // shared time arrives
	input  wire logic [31:0]                          time_val_i,
	output logic                                      tx_valid_o,    // cyclic word out
	input  wire logic                                 tx_ready_i,
	output logic [fieldbus_pkg::DW-1:0]               tx_data_o,
	output logic                                      tx_outs_o,     // word carries valid outputs
	input  wire logic                                 rx_valid_i,    // cyclic input word
	input  wire logic [fieldbus_pkg::DW-1:0]          rx_data_i,
	output logic                                      sdo_link_valid_o,
	input  wire logic                                 sdo_link_ready_i,
	output var fieldbus_pkg::sdo_req_t                sdo_link_req_o,
	// host side
	input  wire logic                                 cfg_valid_i,   // configuration loaded
	input  wire logic                                 rio_mode_i,    // remote i/o mode
	input  wire logic                                 refresh_i,     // host i/o refresh pulse
	input  wire logic [fieldbus_pkg::TBL_AW:0]        tbl_len_i,     // entries in use
	input  wire logic                                 tbl_we_i,
	input  wire logic [fieldbus_pkg::TBL_AW-1:0]      tbl_addr_i,
	input  wire fieldbus_pkg::map_entry_t             tbl_wdata_i,
	output logic                                      host_rd_o,
	output logic                                      host_wr_o,
	output logic [fieldbus_pkg::HOST_AW-1:0]          host_addr_o,
	output logic [fieldbus_pkg::DW-1:0]               host_wdata_o,
	input  wire logic [fieldbus_pkg::DW-1:0]          host_rdata_i,  // valid cycle after host_rd_o
	input  wire logic                                 sdo_valid_i,
	output logic                                      sdo_ready_o,
	input  wire fieldbus_pkg::sdo_req_t               sdo_req_i,
	output var fieldbus_pkg::comm_state_t             state_o,       // status field
	output logic                                      refused_o,     // configuration refused
	output logic                                      led_run_o,
	output logic                                      led_err_o
);
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CYCLE_CYC = CYCLE_NS / fieldbus_pkg::CLK_NS; // whole clocks per cycle

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic                             up_meta_reg;   // first synchroniser stage
	logic                             up_reg;        // synchronised link state
	fieldbus_pkg::comm_state_t        st_reg, st_next;
	fieldbus_pkg::pd_phase_t          pd_reg, pd_next;
	logic [fieldbus_pkg::TBL_AW:0]    idx_reg, idx_next;     // table slot being walked
	logic [7:0]                       pace_reg, pace_next;   // wire pacing
	logic [fieldbus_pkg::DW-1:0]      word_reg, word_next;   // word in flight
	logic                             refused_next;
	logic                             err_reg, err_next;     // last drop came from error
	fieldbus_pkg::map_entry_t         entry;                 // table read data
	logic                             cyc_start;             // control cycle begins
	logic [31:0]                      now;                   // local time base
	logic                             pd_on;                 // cyclic exchange allowed
	logic                             gap;                   // no cyclic exchange running
	logic                             last;                  // current slot is the final one
	logic                             tx_fire, rx_fire;
	logic                             walk_done;             // cyclic exchange ended this clock
	logic                             overrun;               // cycle began before walk ended
	logic                             fault;                 // error pulse or overrun, reason to drop a state; link loss is handled apart

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// state one step below, never below pre-op on a cyclic error
	function automatic fieldbus_pkg::comm_state_t drop(input fieldbus_pkg::comm_state_t s);
		drop = (s == fieldbus_pkg::ST_OP) ? fieldbus_pkg::ST_SAFEOP : fieldbus_pkg::ST_PREOP;
	endfunction

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	cycle_timer #(.CYCLE_CYC(CYCLE_CYC)) u_timer (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.rio_mode_i (rio_mode_i),
		.refresh_i  (refresh_i),
		.time_load_i(time_load_i),
		.time_val_i (time_val_i),
		.start_o    (cyc_start),
		.time_o     (now)
	);

	// table lookup of the slot being walked [RQ14]
	// read address leads by one clock so the registered entry always matches idx_reg
	pdo_map_mem u_map (
		.clk_i  (clk_i),
		.we_i   (tbl_we_i),
		.waddr_i(tbl_addr_i),
		.wdata_i(tbl_wdata_i),
		.raddr_i(idx_next[fieldbus_pkg::TBL_AW-1:0]),
		.rdata_o(entry)
	);

	// ---------------------------------------------------------------
	// decoding
	// ---------------------------------------------------------------
	assign pd_on     = (st_reg == fieldbus_pkg::ST_SAFEOP) || (st_reg == fieldbus_pkg::ST_OP); // [RQ4] [RQ6]
	assign gap       = (pd_reg == fieldbus_pkg::PD_IDLE);
	assign last      = (idx_reg + 5'h01 >= tbl_len_i);
	assign tx_fire   = tx_valid_o && tx_ready_i;
	assign rx_fire   = (pd_reg == fieldbus_pkg::PD_RECV) && rx_valid_i;
	assign walk_done = last && (((pd_reg == fieldbus_pkg::PD_SEND) && tx_fire) || (pd_reg == fieldbus_pkg::PD_STORE));
	assign overrun   = cyc_start && !gap;
	assign fault     = link_err_i || overrun;

	// ---------------------------------------------------------------
	// link pin synchroniser
	// ---------------------------------------------------------------
	// two stages before anything looks at the link pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			up_meta_reg <= 1'b0;
			up_reg      <= 1'b0;
		end else begin
			up_meta_reg <= link_up_i;
			up_reg      <= up_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// communications state machine
	// ---------------------------------------------------------------
	// moves on link events alone, the host only supplies configuration [RQ10]
	always_comb begin
		st_next      = st_reg;
		refused_next = refused_o && cfg_valid_i; // cleared when host withdraws configuration
		err_next     = err_reg;
		case (st_reg)
			fieldbus_pkg::ST_INIT: begin
				if (up_reg && cfg_valid_i && scan_done_i && !refused_o) begin
					if (unsupported_i) begin
						refused_next = 1'b1;                 // [RQ15]
					end else begin
						st_next  = fieldbus_pkg::ST_PREOP;   // [RQ6] [RQ16]
						err_next = 1'b0;
					end
				end
			end
			fieldbus_pkg::ST_PREOP: begin
				if (setup_done_i) begin
					st_next = fieldbus_pkg::ST_SAFEOP;       // [RQ16]
				end
			end
			fieldbus_pkg::ST_SAFEOP: begin
				if (fault) begin
					st_next  = drop(st_reg);                 // [RQ16]
					err_next = 1'b1;
				end else if (walk_done) begin
					st_next  = fieldbus_pkg::ST_OP;          // inputs now in hand [RQ8]
					err_next = 1'b0;
				end
			end
			fieldbus_pkg::ST_OP: begin
				if (fault) begin
					st_next  = drop(st_reg);                 // outputs blocked again [RQ16]
					err_next = 1'b1;
				end
			end
			default: begin
				st_next = fieldbus_pkg::ST_INIT;
			end
		endcase
		// losing the link always restarts from init
		if (!up_reg) begin
			st_next = fieldbus_pkg::ST_INIT;
		end
	end

	// state registers, init right after reset [RQ5]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg    <= fieldbus_pkg::ST_INIT;              // [RQ5]
			refused_o <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			st_reg    <= st_next;
			refused_o <= refused_next;
			err_reg   <= err_next;
		end
	end

	// ---------------------------------------------------------------
	// cyclic exchange walker
	// ---------------------------------------------------------------
	// one pass over the table per control cycle [RQ2] [RQ14]
	always_comb begin
		pd_next   = pd_reg;
		idx_next  = idx_reg;
		word_next = word_reg;
		pace_next = (pace_reg == fieldbus_pkg::PACE_ZERO) ? pace_reg : pace_reg - 8'h01;
		case (pd_reg)
			fieldbus_pkg::PD_IDLE: begin
				idx_next = '0;
				if (cyc_start && pd_on && (tbl_len_i != '0)) begin
					pd_next = fieldbus_pkg::PD_MAP;          // [RQ2]
				end
			end
			fieldbus_pkg::PD_MAP: begin
				pd_next = entry.is_out ? fieldbus_pkg::PD_FETCH : fieldbus_pkg::PD_RECV;
			end
			fieldbus_pkg::PD_FETCH: begin
				pd_next = fieldbus_pkg::PD_LOAD;
			end
			fieldbus_pkg::PD_LOAD: begin
				// safe-op sends cleared words so no slave applies outputs [RQ7]
				word_next = (st_reg == fieldbus_pkg::ST_OP) ? host_rdata_i : '0; // [RQ7] [RQ9]
				pd_next   = fieldbus_pkg::PD_SEND;
			end
			fieldbus_pkg::PD_SEND: begin
				if (tx_fire) begin
					pace_next = 8'(fieldbus_pkg::WORD_CYC);  // [RQ1]
					idx_next  = idx_reg + 5'h01;
					pd_next   = last ? fieldbus_pkg::PD_IDLE : fieldbus_pkg::PD_MAP;
				end
			end
			fieldbus_pkg::PD_RECV: begin
				if (rx_fire) begin
					word_next = rx_data_i;
					pd_next   = fieldbus_pkg::PD_STORE;
				end
			end
			fieldbus_pkg::PD_STORE: begin
				idx_next = idx_reg + 5'h01;
				pd_next  = last ? fieldbus_pkg::PD_IDLE : fieldbus_pkg::PD_MAP;
			end
			default: begin
				pd_next = fieldbus_pkg::PD_IDLE;
			end
		endcase
		// leaving the cyclic states aborts the pass at once [RQ4]
		if (!pd_on || fault) begin
			pd_next = fieldbus_pkg::PD_IDLE;
		end
	end

	// walker registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_reg   <= fieldbus_pkg::PD_IDLE;
			idx_reg  <= '0;
			pace_reg <= fieldbus_pkg::PACE_ZERO;
			word_reg <= '0;
		end else begin
			pd_reg   <= pd_next;
			idx_reg  <= idx_next;
			pace_reg <= pace_next;
			word_reg <= word_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign link_fdx_o   = 1'b1;                                                // [RQ1]
	assign link_100_o   = 1'b1;                                                // [RQ1]
	assign tx_valid_o   = (pd_reg == fieldbus_pkg::PD_SEND) && (pace_reg == fieldbus_pkg::PACE_ZERO) && pd_on;
	assign tx_data_o    = word_reg;
	assign tx_outs_o    = tx_valid_o && (st_reg == fieldbus_pkg::ST_OP);        // [RQ7] [RQ9]
	assign host_rd_o    = (pd_reg == fieldbus_pkg::PD_FETCH);                   // [RQ13] [RQ14]
	assign host_wr_o    = (pd_reg == fieldbus_pkg::PD_STORE);                   // [RQ13] [RQ14]
	assign host_addr_o  = entry.host_word;                                      // [RQ14]
	assign host_wdata_o = word_reg;
	// acyclic traffic only in the gap and never in init [RQ3] [RQ4]
	assign sdo_link_valid_o = sdo_valid_i && gap && (st_reg != fieldbus_pkg::ST_INIT); // [RQ3] [RQ4]
	assign sdo_ready_o      = sdo_link_ready_i && gap && (st_reg != fieldbus_pkg::ST_INIT);
	assign sdo_link_req_o   = sdo_req_i;
	// status field and front indicators: off, flashing, steady [RQ11]
	assign state_o   = st_reg;                                                  // [RQ11]
	assign led_run_o = (st_reg == fieldbus_pkg::ST_OP) ||
	                   ((st_reg != fieldbus_pkg::ST_INIT) && now[fieldbus_pkg::BLINK_BIT]); // [RQ11]
	assign led_err_o = refused_o || err_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	init_quiet_a: assert property (st_reg == fieldbus_pkg::ST_INIT |-> !tx_valid_o && !sdo_link_valid_o) // [RQ4]
		else $error("traffic in init");
	preop_no_cyclic_a: assert property (st_reg == fieldbus_pkg::ST_PREOP |-> !tx_valid_o && !host_rd_o) // [RQ6]
		else $error("cyclic traffic in pre-op");
	safeop_no_out_a: assert property (tx_valid_o && st_reg != fieldbus_pkg::ST_OP |-> tx_data_o == '0 && !tx_outs_o) // [RQ7]
		else $error("outputs sent outside operational");
	sdo_in_gap_a: assert property (sdo_link_valid_o |-> pd_reg == fieldbus_pkg::PD_IDLE) // [RQ3]
		else $error("acyclic request during cyclic exchange");
	op_entry_a: assert property ($rose(st_reg == fieldbus_pkg::ST_OP) |-> $past(st_reg) == fieldbus_pkg::ST_SAFEOP && $past(walk_done)) // [RQ8]
		else $error("operational entered without inputs");
	step_order_a: assert property (st_reg != $past(st_reg) && st_reg > $past(st_reg) |-> st_reg == $past(st_reg) + 2'd1) // [RQ16]
		else $error("state skipped a step");
	reset_init_a: assert property ($fell(rst_i) |-> st_reg == fieldbus_pkg::ST_INIT) // [RQ5]
		else $error("not in init after reset");
	refuse_hold_a: assert property (refused_o |-> st_reg == fieldbus_pkg::ST_INIT) // [RQ15]
		else $error("communications with refused configuration");
	walk_start_a: assert property (cyc_start && pd_on && gap && tbl_len_i != '0 && !fault && up_reg |=> pd_reg == fieldbus_pkg::PD_MAP) // [RQ2]
		else $error("cyclic exchange not started");
	fault_drop_a: assert property (st_reg == fieldbus_pkg::ST_OP && link_err_i |=> st_reg != fieldbus_pkg::ST_OP) // [RQ16]
		else $error("error did not block outputs");

	reach_op_c: cover property (st_reg == fieldbus_pkg::ST_SAFEOP ##1 st_reg == fieldbus_pkg::ST_OP);
	refused_c: cover property ($rose(refused_o));
	sdo_sent_c: cover property (sdo_link_valid_o && sdo_link_ready_i && st_reg == fieldbus_pkg::ST_OP);
	op_error_c: cover property (st_reg == fieldbus_pkg::ST_OP ##1 st_reg == fieldbus_pkg::ST_SAFEOP);
endmodule
`default_nettype wire

// ---- core/fieldbus_pkg.sv ----
// shared constants, states and carriers of the fieldbus master state control
`default_nettype none
package fieldbus_pkg;
	// ---------------------------------------------------------------
	// clock and link timing
	// ---------------------------------------------------------------
	localparam int CLK_NS       = 10;     // 100 MHz system clock
	localparam int LINK_MBPS    = 100;    // full-duplex link rate
	localparam int BYTE_NS      = 8000 / LINK_MBPS; // one byte on the wire
	localparam int WORD_BYTES   = 4;      // one process word is four bytes
	// a process word may not leave faster than the wire can carry it
	localparam int WORD_CYC     = (WORD_BYTES * BYTE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYCLE_NS_DEF = 250000; // default control cycle, 250 us
	localparam int BLINK_BIT    = 27;     // time base bit for indicator flashing

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int DW       = 32;         // process word width
	localparam int TBL_AW   = 4;          // process data table index width
	localparam int TBL_DEPTH = 16;        // process data table entries
	localparam int HOST_AW  = 8;          // host word address width
	localparam logic [7:0] PACE_ZERO = 8'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	// communications states, lowest first
	typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} comm_state_t;
	// phases of one cyclic exchange
	typedef enum logic [2:0] {PD_IDLE, PD_MAP, PD_FETCH, PD_LOAD, PD_SEND, PD_RECV, PD_STORE} pd_phase_t;
	// one process data table entry
	typedef struct packed {
		logic               is_out;    // 1: host word goes out, 0: input comes in
		logic [HOST_AW-1:0] host_word; // host memory word mapped to this slot
	} map_entry_t;
	// one acyclic parameter request
	typedef struct packed {
		logic          write;          // 1: write, 0: read
		logic [15:0]   index;          // object dictionary index
		logic [7:0]    sub;            // sub-index
		logic [DW-1:0] data;           // write data
	} sdo_req_t;
endpackage
`default_nettype wire

// ---- core/pdo_map_mem.sv ----
// process data table memory: one write port, registered read
`default_nettype none
module pdo_map_mem (
	input  wire logic                               clk_i,
	input  wire logic                               we_i,
	input  wire logic [fieldbus_pkg::TBL_AW-1:0]    waddr_i,
	input  wire fieldbus_pkg::map_entry_t           wdata_i,
	input  wire logic [fieldbus_pkg::TBL_AW-1:0]    raddr_i,
	output var fieldbus_pkg::map_entry_t            rdata_o
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	fieldbus_pkg::map_entry_t mem [fieldbus_pkg::TBL_DEPTH]; // table body

	// write and registered read; content needs no reset, host loads it
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

// ---- core/cycle_timer.sv ----
// control cycle generator and local distributed time base
`default_nettype none
module cycle_timer #(
	parameter int unsigned CYCLE_CYC = 25000 // clocks per control cycle
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      rio_mode_i,  // cycle follows host refresh
	input  wire logic                      refresh_i,   // host refresh pulse
	input  wire logic                      time_load_i, // shared time arrives
	input  wire logic [31:0]               time_val_i,  // shared time in ns
	output logic                           start_o,     // one-cycle cycle start
	output logic [31:0]                    time_o       // local time in ns
);
	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	logic [31:0] cnt_reg;   // clocks into the current cycle
	logic [31:0] cnt_next;
	logic        wrap;      // last clock of the cycle
	logic [31:0] time_next;

	assign wrap      = (cnt_reg == 32'(CYCLE_CYC - 1));
	assign cnt_next  = wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
	// the time base is overwritten by the shared value so all nodes agree [RQ12]
	assign time_next = time_load_i ? time_val_i : time_o + 32'(fieldbus_pkg::CLK_NS); // [RQ12]

	// cycle counter and time base
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 32'h0000_0000;
			time_o  <= 32'h0000_0000;
			start_o <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			time_o  <= time_next;
			// remote i/o mode ties each exchange to a host refresh [RQ13]
			start_o <= rio_mode_i ? refresh_i : wrap; // [RQ2] [RQ13]
		end
	end
endmodule
`default_nettype wire

// ---- sim/slave_model.sv ----
// behavioural fieldbus slave: takes output words, offers inputs, answers acyclic requests
`default_nettype none
module slave_model (
	input  wire logic        clk_i,
	input  wire logic        slow_i,       // stall the cyclic stream
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic             rx_valid_o,
	output logic [31:0]      rx_data_o,
	input  wire logic        sdo_valid_i,
	output logic             sdo_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// pacing
	// ---------------------------------------------------------------
	logic [7:0] tick_reg = 8'h00; // free count, paces stalls and inputs
	always_ff @(posedge clk_i) begin
		tick_reg <= tick_reg + 8'h01;
	end
	// a stalled slave lets one cycle in four through
	assign tx_ready_o = !slow_i || (tick_reg[1:0] == 2'h3);
	// inputs every other cycle; between them the line shows the inverse
	assign rx_valid_o = tick_reg[0];
	assign rx_data_o  = tick_reg[0] ? {8'h5A, 16'h0000, tick_reg} : ~{8'h5A, 16'h0000, tick_reg};
	// acyclic requests are answered at once when offered
	assign sdo_ready_o = 1'h1;
endmodule
`default_nettype wire

// ---- sim/test_fieldbus_master_state_control.sv ----
// self-checking bench for the fieldbus master state control
`default_nettype none
module test_fieldbus_master_state_control;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk_i, rst_i, link, cfg, scan, unsup, setup, lerr, txr, rxv, slr, sdov, slow, tbl_we, tload, rio, refr;
	logic fdx, f100, txv, touts, slv, hrd, hwr, refused, lrun, lerr_o, sdor;
	logic [31:0]               rxd, hrdata, txd, hwdata;
	logic [7:0]                haddr;
	logic [3:0]                tbl_addr;
	logic [4:0]                tbl_len;
	fieldbus_pkg::map_entry_t  tbl_wdata;
	fieldbus_pkg::sdo_req_t    sreq, slreq;
	fieldbus_pkg::comm_state_t st;
	int num_errors = 0, checked = 0, cyc = 0, gap = 100, n;
	// rows: {link, cfg, scan, unsupported, setup} beside state and refusal
	typedef struct packed {logic [4:0] in; fieldbus_pkg::comm_state_t st; logic rf;} row_t;
	row_t rows[4] = '{'{5'h1E, fieldbus_pkg::ST_INIT, 1'h1}, '{5'h16, fieldbus_pkg::ST_INIT, 1'h0},
		'{5'h1C, fieldbus_pkg::ST_PREOP, 1'h0}, '{5'h1D, fieldbus_pkg::ST_SAFEOP, 1'h0}};
	// ---------------------------------------------------------------
	// design, slave and host memory
	// ---------------------------------------------------------------
	fieldbus_master_state_control #(.CYCLE_NS(2000)) uut (.clk_i(clk_i), .rst_i(rst_i), .link_up_i(link),
		.link_fdx_o(fdx), .link_100_o(f100), .scan_done_i(scan), .unsupported_i(unsup), .setup_done_i(setup),
		.link_err_i(lerr), .time_load_i(tload), .time_val_i(32'h08000000), .tx_valid_o(txv), .tx_ready_i(txr),
		.tx_data_o(txd), .tx_outs_o(touts), .rx_valid_i(rxv), .rx_data_i(rxd), .sdo_link_valid_o(slv),
		.sdo_link_ready_i(slr), .sdo_link_req_o(slreq), .cfg_valid_i(cfg), .rio_mode_i(rio),
		.refresh_i(refr), .tbl_len_i(tbl_len), .tbl_we_i(tbl_we), .tbl_addr_i(tbl_addr),
		.tbl_wdata_i(tbl_wdata), .host_rd_o(hrd), .host_wr_o(hwr), .host_addr_o(haddr),
		.host_wdata_o(hwdata), .host_rdata_i(hrdata), .sdo_valid_i(sdov), .sdo_ready_o(sdor),
		.sdo_req_i(sreq), .state_o(st), .refused_o(refused), .led_run_o(lrun), .led_err_o(lerr_o));
	slave_model partner (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(txv), .tx_ready_o(txr),
		.rx_valid_o(rxv), .rx_data_o(rxd), .sdo_valid_i(slv), .sdo_ready_o(slr));
	// host memory answers one cycle after the read strobe with its address in the low byte
	always @(posedge clk_i) hrdata <= 32'hC0DE0000 | {24'h0, haddr};
	always #5 clk_i = ~clk_i;
	// ---------------------------------------------------------------
	// watchers and timeout
	// ---------------------------------------------------------------
	always @(posedge clk_i) begin
		cyc++;
		gap++;
		if (txv && txr) begin
			`CHK("word pace", 1'h1, gap >= 32)
			if (st !== fieldbus_pkg::ST_OP) `CHK("safe word", 33'h0, {touts, txd})
			gap = 0;
		end
		if (!rst_i && st === fieldbus_pkg::ST_INIT) `CHK("init quiet", 3'h0, {txv, sdor, hwr})
		if (hwr) `CHK("input slot", 16'h095A, {haddr, hwdata[31:24]})
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// request held until ready is seen, released on the taking edge
	task automatic sdo_xfer(input fieldbus_pkg::sdo_req_t r);
		n = 0;
		@(posedge clk_i) {sdov, sreq} <= {1'h1, r};
		do begin @(negedge clk_i); n++; end while (sdor !== 1'h1 && n < 300);
		`CHK("sdo pass", {1'h1, r}, {slv, slreq})
		@(posedge clk_i) sdov <= 1'h0;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{clk_i, rst_i, link, cfg, scan, unsup, setup, lerr, sdov, slow, tbl_we} = 11'h200;
		{sreq, tbl_addr, tbl_len, tbl_wdata, tload, rio, refr} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(negedge clk_i);
		`CHK("reset state", fieldbus_pkg::ST_INIT, st)
		`CHK("link mode", 2'h3, {fdx, f100})
		$display("test reset done");
		@(posedge clk_i) {tbl_we, tbl_addr, tbl_wdata, tbl_len} <= {1'h1, 4'h0, 1'h1, 8'h05, 5'h02};
		@(posedge clk_i) {tbl_addr, tbl_wdata} <= {4'h1, 1'h0, 8'h09};
		@(posedge clk_i) tbl_we <= 1'h0;
		foreach (rows[i]) begin
			@(posedge clk_i) {link, cfg, scan, unsup, setup} <= rows[i].in;
			repeat (6) @(posedge clk_i);
			@(negedge clk_i);
			`CHK("row state", rows[i].st, st)
			`CHK("row refused", rows[i].rf, refused)
		end
		$display("test rows done");
		sdo_xfer({1'h1, 16'h6040, 8'h00, 32'h0000000F});
		n = 0;
		while (st !== fieldbus_pkg::ST_OP && n < 1000) begin @(negedge clk_i); n++; end
		`CHK("operational", 2'h3, {st === fieldbus_pkg::ST_OP, lrun})
		@(posedge clk_i) slow <= 1'h1;
		n = 0;
		do begin @(negedge clk_i); n++; end while (!(txv && txr) && n < 400);
		`CHK("cycle period", 1'h1, n < 240)
		`CHK("output word", {1'h1, 32'hC0DE0005}, {touts, txd})
		$display("test walk done");
		@(posedge clk_i) lerr <= 1'h1;
		@(posedge clk_i) lerr <= 1'h0;
		@(negedge clk_i);
		`CHK("error drop", {fieldbus_pkg::ST_SAFEOP, 1'h1}, {st, lerr_o})
		// host refresh starts the pass in remote i/o mode; shared time sets the flash bit
		@(posedge clk_i) {rio, refr, tload} <= 3'h7;
		@(posedge clk_i) {refr, tload} <= 2'h0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		`CHK("host refresh", 2'h3, {hrd, lrun})
		@(posedge clk_i) link <= 1'h0;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		`CHK("link loss", {fieldbus_pkg::ST_INIT, 1'h0}, {st, lrun})
		$display("test errors done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
